//--- ppm_peripheral_port_pin_mux.sv
// peripheral port pin mux, strobes, straps and wavetable receive path
`timescale 1ns/1ps

// ===================================================
// small synchronous fifo
module ppm_fifo import ppm_pkg::*; #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic doWrite;
  logic doRead;

  assign inReady = count_q != FULL_CNT;
  assign outValid = count_q != '0;
  assign outData = mem[rdPtr_q];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead && !doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ===================================================
// top of the pin mux
module ppm_peripheral_port_pin_mux import ppm_pkg::*; (
  // clock and reset (reset is the reset drive input)
  input wire logic core_clk,
  input wire logic rst,
  // host cycle and decode results
  input wire logic [2:0] hostAddr,
  input wire logic [7:0] hostData,
  input wire logic hostReadN,
  input wire logic hostWriteN,
  input wire logic synthDecode,
  input wire logic cdromDecode,
  input wire logic modemDecode,
  input wire logic altCdromDecode,
  // configuration bits
  input wire logic internalFmEnable,
  input wire logic volumePinsEnable,
  input wire logic [PPM_ALT_BASE_W-1:0] altCdromBase,
  input wire logic synthIrqPolarity,
  input wire logic serialPortSwitch,
  input wire logic serialPortEnable,
  input wire logic wavetablePortEnable,
  input wire logic eepromAccessEnable,
  input wire logic wideAddrEnable,
  input wire logic controlZeroBit,
  input wire logic controlOneBit,
  input wire logic bufferedResetBit,
  input wire logic masterClockDisable,
  // eeprom engine
  input wire logic eepromClk,
  input wire logic eepromSdaOut,
  output logic eepromSdaIn,
  // dsp serial port
  input wire logic dspSerialOut,
  input wire logic dspSerialClk,
  input wire logic dspFrameSync,
  output logic dspSerialIn,
  // dac path mixing
  input wire logic dacValid,
  input wire ppm_stereo_s dacIn,
  output logic mixValid,
  output ppm_stereo_s mixOut,
  output logic wtDropped,
  // status
  output logic upperAddrMode,
  output logic cdromPortsEnable,
  output logic synthIrq,
  output logic volumeUp,
  output logic volumeDown,
  output logic [3:0] stickBInputs,
  output logic [7:0] periphReadData,
  output logic periphReadEnable,
  // synth select / volume up pin
  output logic synthSelectNOut,
  output logic synthSelectNOe,
  input wire logic synthSelectNIn,
  // control-1 / synth irq / alt cdrom select / volume down pin
  output logic extControlOneOut,
  output logic extControlOneOe,
  input wire logic extControlOneIn,
  // address and select pins
  output logic extControlZero,
  output logic extAddrOne,
  output logic extAddrZero,
  output logic cdromSelectN,
  output logic modemSelectN,
  output logic bufferedResetN,
  // strobe pins, read back as straps during reset
  output logic extReadStrobeNOut,
  output logic extReadStrobeNOe,
  input wire logic extReadStrobeNIn,
  output logic extWriteStrobeNOut,
  output logic extWriteStrobeNOe,
  input wire logic extWriteStrobeNIn,
  // external data bus pins
  output logic [7:0] extDataBusOut,
  output logic [7:0] extDataBusOe,
  input wire logic [7:0] extDataBusIn,
  // joystick B pins
  output logic [3:0] stickBPinOut,
  output logic [3:0] stickBPinOe,
  input wire logic [3:0] stickBPinIn
);
  logic [PPM_SYNC_W-1:0] pinRaw;
  logic [PPM_SYNC_W-1:0] syncA_q;
  logic [PPM_SYNC_W-1:0] syncB_q;
  logic [PPM_SYNC_W-1:0] syncC_q;
  logic [PPM_SYNC_W-1:0] filt_q;
  logic pcmLate_q;
  logic rstPrev_q;
  logic strapRead_q;
  logic strapWrite_q;
  logic altEver_q;
  ppm_ctl1_mode_e ctl1Mode;
  logic synthSel;
  logic anySel;
  logic periphWrite;
  logic serialOnXd;
  logic serialOnStick;
  logic mclkGate_q;
  ppm_bus_drive_s xdDrive;
  logic alignPrev_q;
  logic wtEdge;
  logic [4:0] bitCnt_q;
  logic [PPM_SAMPLE_W-1:0] shift_q;
  logic pushValid_q;
  ppm_wt_word_s pushWord_q;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  ppm_wt_word_s fifoOut;
  logic [PPM_SAMPLE_W-1:0] holdL_q;
  logic [PPM_SAMPLE_W-1:0] holdR_q;
  logic fullL_q;
  logic fullR_q;
  logic popL;
  logic popR;

  // signed add clamped to the sample range
  function automatic logic [PPM_SAMPLE_W-1:0] ppmSatAdd(input logic [PPM_SAMPLE_W-1:0] a,
                                                         input logic [PPM_SAMPLE_W-1:0] b);
    logic [PPM_SAMPLE_W:0] s;
    s = {a[PPM_SAMPLE_W-1], a} + {b[PPM_SAMPLE_W-1], b};
    if (s[PPM_SAMPLE_W] != s[PPM_SAMPLE_W-1]) begin
      return s[PPM_SAMPLE_W] ? 16'h8000 : 16'h7FFF;
    end
    return s[PPM_SAMPLE_W-1:0];
  endfunction

  // ===================================================
  // pin input synchronisers with agreement filter
  assign pinRaw = {extDataBusIn, stickBPinIn, extWriteStrobeNIn, extReadStrobeNIn, extControlOneIn, synthSelectNIn};

  always_ff @(posedge core_clk) begin
    syncA_q <= pinRaw;
    syncB_q <= syncA_q;
    syncC_q <= syncB_q;
    filt_q <= (syncB_q & syncC_q) | (filt_q & (syncB_q ^ syncC_q));
    // serial data bit taken after the third stage, one stage later to line up with the filtered align level;
    // the agreement filter would swallow a lone bit of a one-bit-per-clock stream
    pcmLate_q <= syncC_q[PPM_IN_XD+PPM_XD_WT_PCM];
  end

  // ===================================================
  // straps caught at reset release
  always_ff @(posedge core_clk) begin
    rstPrev_q <= rst;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strapRead_q <= PPM_STRAP_RD_RST;
      strapWrite_q <= PPM_STRAP_WR_RST;
    end else if (rstPrev_q) begin
      strapRead_q <= filt_q[PPM_IN_STRAP_RD];
      strapWrite_q <= filt_q[PPM_IN_STRAP_WR];
    end
  end

  assign upperAddrMode = strapRead_q;
  assign cdromPortsEnable = !strapRead_q;

  // ===================================================
  // alt cdrom base seen non-zero, held until reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      altEver_q <= 1'b0;
    end else if (altCdromBase != '0) begin
      altEver_q <= 1'b1;
    end
  end

  // ===================================================
  // shared pin function selection
  always_comb begin
    if (volumePinsEnable) begin
      ctl1Mode = PPM_CTL1_VOLDN;
    end else if (altEver_q) begin
      ctl1Mode = PPM_CTL1_ALTCD;
    end else if (!strapWrite_q) begin
      ctl1Mode = PPM_CTL1_IRQ;
    end else begin
      ctl1Mode = PPM_CTL1_OUT;
    end
  end

  assign extControlOneOe = (ctl1Mode == PPM_CTL1_OUT) || (ctl1Mode == PPM_CTL1_ALTCD);
  assign extControlOneOut = (ctl1Mode == PPM_CTL1_ALTCD) ? !altCdromDecode : controlOneBit;
  assign volumeDown = (ctl1Mode == PPM_CTL1_VOLDN) && !filt_q[PPM_IN_CTL1];
  assign synthIrq = (ctl1Mode == PPM_CTL1_IRQ)
                    && (filt_q[PPM_IN_CTL1] == synthIrqPolarity);

  assign synthSel = synthDecode && !internalFmEnable && !volumePinsEnable;
  assign synthSelectNOe = !internalFmEnable && !volumePinsEnable;
  assign synthSelectNOut = !synthSel;
  assign volumeUp = volumePinsEnable && !filt_q[PPM_IN_SYNTH];

  // ===================================================
  // address, selects, strobes and buffered reset
  assign extControlZero = wideAddrEnable ? hostAddr[2] : controlZeroBit;
  assign extAddrOne = hostAddr[1];
  assign extAddrZero = eepromAccessEnable ? eepromClk : hostAddr[0];
  assign cdromSelectN = !(cdromDecode && cdromPortsEnable);
  assign modemSelectN = !(modemDecode && cdromPortsEnable);
  assign anySel = synthSel || !cdromSelectN || !modemSelectN;
  assign periphWrite = anySel && !hostWriteN;
  assign extReadStrobeNOut = !(anySel && !hostReadN);
  assign extWriteStrobeNOut = !periphWrite;
  assign extReadStrobeNOe = !rst;
  assign extWriteStrobeNOe = !rst;
  assign bufferedResetN = !(rst || bufferedResetBit);

  // ===================================================
  // external data bus and serial port routing
  assign serialOnXd = serialPortEnable && serialPortSwitch;
  assign serialOnStick = serialPortEnable && !serialPortSwitch;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mclkGate_q <= 1'b0;
    end else begin
      mclkGate_q <= wavetablePortEnable && !masterClockDisable;
    end
  end

  always_comb begin
    xdDrive.o = {hostData[7:1], 1'b0};
    xdDrive.oe = {{7{periphWrite}}, 1'b0};
    if (eepromAccessEnable) begin
      xdDrive.oe[0] = !eepromSdaOut;
    end else begin
      xdDrive.oe[0] = periphWrite && !hostData[0];
    end
    if (serialOnXd) begin
      xdDrive.o[PPM_XD_SER_CLK] = dspSerialClk;
      xdDrive.oe[PPM_XD_SER_CLK] = 1'b1;
      xdDrive.oe[PPM_XD_SER_IN] = 1'b0;
      xdDrive.o[PPM_XD_SER_OUT] = dspSerialOut;
      xdDrive.oe[PPM_XD_SER_OUT] = 1'b1;
      xdDrive.o[PPM_XD_SER_SYNC] = dspFrameSync;
      xdDrive.oe[PPM_XD_SER_SYNC] = 1'b1;
    end
    if (wavetablePortEnable) begin
      xdDrive.o[PPM_XD_WT_MCLK] = core_clk && mclkGate_q;
      xdDrive.oe[PPM_XD_WT_MCLK] = 1'b1;
      xdDrive.oe[PPM_XD_WT_ALIGN] = 1'b0;
      xdDrive.oe[PPM_XD_WT_PCM] = 1'b0;
    end
  end

  assign extDataBusOut = xdDrive.o;
  assign extDataBusOe = xdDrive.oe;
  assign eepromSdaIn = filt_q[PPM_IN_XD];
  assign periphReadData = filt_q[PPM_IN_XD+7:PPM_IN_XD];
  assign periphReadEnable = !(serialOnXd || wavetablePortEnable);

  assign stickBPinOut = {dspSerialClk, dspFrameSync, 1'b0, dspSerialOut};
  assign stickBPinOe = {serialOnStick, serialOnStick, 1'b0, serialOnStick};
  assign stickBInputs = filt_q[PPM_IN_STICK+3:PPM_IN_STICK];
  assign dspSerialIn = serialOnXd ? filt_q[PPM_IN_XD+PPM_XD_SER_IN]
                                  : filt_q[PPM_IN_STICK+PPM_STICK_Y];

  // ===================================================
  // wavetable word receiver, one bit per clock
  assign wtEdge = filt_q[PPM_IN_XD+PPM_XD_WT_ALIGN] != alignPrev_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      alignPrev_q <= 1'b0;
      bitCnt_q <= PPM_BITCNT_RST;
      shift_q <= '0;
      pushValid_q <= 1'b0;
      pushWord_q <= '0;
    end else begin
      alignPrev_q <= filt_q[PPM_IN_XD+PPM_XD_WT_ALIGN];
      pushValid_q <= 1'b0;
      if (!wavetablePortEnable) begin
        bitCnt_q <= PPM_BITCNT_RST;
      end else if (wtEdge) begin
        shift_q <= {shift_q[PPM_SAMPLE_W-2:0], pcmLate_q};
        bitCnt_q <= 5'h01;
      end else if (bitCnt_q != PPM_BITCNT_FULL) begin
        shift_q <= {shift_q[PPM_SAMPLE_W-2:0], pcmLate_q};
        bitCnt_q <= bitCnt_q + 5'h01;
        if (bitCnt_q == 5'(PPM_WORD_LAST)) begin
          pushValid_q <= 1'b1;
          pushWord_q.right <= !filt_q[PPM_IN_XD+PPM_XD_WT_ALIGN];
          pushWord_q.data <= {shift_q[PPM_SAMPLE_W-2:0], pcmLate_q};
        end
      end
    end
  end

  assign wtDropped = pushValid_q && !fifoInReady;

  ppm_fifo #(
    .WIDTH(PPM_SAMPLE_W + 1),
    .DEPTH(PPM_FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .inValid(pushValid_q),
    .inReady(fifoInReady),
    .inData(pushWord_q),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // ===================================================
  // digital sum into the dac path
  assign fifoOutReady = fifoOut.right ? !fullR_q : !fullL_q;
  assign popL = fifoOutValid && !fifoOut.right && !fullL_q;
  assign popR = fifoOutValid && fifoOut.right && !fullR_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdL_q <= '0;
      holdR_q <= '0;
      fullL_q <= 1'b0;
      fullR_q <= 1'b0;
    end else begin
      if (popL) begin
        holdL_q <= fifoOut.data;
      end
      if (popR) begin
        holdR_q <= fifoOut.data;
      end
      fullL_q <= popL || (fullL_q && !dacValid);
      fullR_q <= popR || (fullR_q && !dacValid);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mixValid <= 1'b0;
      mixOut <= '0;
    end else begin
      mixValid <= dacValid;
      if (dacValid) begin
        mixOut.left <= ppmSatAdd(dacIn.left, fullL_q ? holdL_q : '0);
        mixOut.right <= ppmSatAdd(dacIn.right, fullR_q ? holdR_q : '0);
      end
    end
  end

  // ===================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_synth_select;
    synthDecode && !internalFmEnable && !volumePinsEnable |-> synthSelectNOe && !synthSelectNOut;
  endproperty
  a_synth_select: assert property (p_synth_select) else $error("synth select not driven low");

  property p_internal_fm;
    internalFmEnable || volumePinsEnable |-> !synthSelectNOe && synthSelectNOut;
  endproperty
  a_internal_fm: assert property (p_internal_fm) else $error("synth select driven while released");

  property p_vol_priority;
    volumePinsEnable |-> !extControlOneOe && !synthIrq && (volumeDown == !filt_q[PPM_IN_CTL1]);
  endproperty
  a_vol_priority: assert property (p_vol_priority) else $error("volume pins lost priority");

  property p_alt_sticky;
    (altCdromBase != '0) ##1 (!volumePinsEnable)[*2] |-> extControlOneOe && (extControlOneOut == !altCdromDecode);
  endproperty
  a_alt_sticky: assert property (p_alt_sticky) else $error("alt cdrom select not kept");

  property p_strap_hold;
    !rst && !rstPrev_q |=> $stable(strapWrite_q) && $stable(strapRead_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed outside reset");

  property p_buffered_reset;
    bufferedResetBit |-> !bufferedResetN;
  endproperty
  a_buffered_reset: assert property (p_buffered_reset) else $error("buffered reset not low");

  property p_strobes;
    anySel |-> (extReadStrobeNOut == hostReadN) && (extWriteStrobeNOut == hostWriteN);
  endproperty
  a_strobes: assert property (p_strobes) else $error("external strobe mismatch");

  property p_eeprom_clk;
    eepromAccessEnable |-> extAddrZero == eepromClk;
  endproperty
  a_eeprom_clk: assert property (p_eeprom_clk) else $error("address 0 not eeprom clock");

  sequence s_word_start;
    wtEdge && wavetablePortEnable;
  endsequence
  sequence s_word_body;
    (!wtEdge && wavetablePortEnable)[*8] ##1 (!wtEdge && wavetablePortEnable)[*7];
  endsequence
  property p_word_push;
    s_word_start ##1 s_word_body |=> pushValid_q;
  endproperty
  a_word_push: assert property (p_word_push) else $error("wavetable word not pushed");

  property p_mix_sum;
    dacValid && !fullL_q |=> mixValid && (mixOut.left == $past(dacIn.left));
  endproperty
  a_mix_sum: assert property (p_mix_sum) else $error("dac pass-through wrong");
endmodule

//--- ppm_peripheral_port_pin_mux_tb.sv
// self-checking bench for the peripheral port pin mux
`timescale 1ns/1ps
module ppm_peripheral_port_pin_mux_tb import ppm_pkg::*; ;
  logic core_clk, rst, rdN, wrN, sDec, cDec, mDec, aDec, fm, vol, pol, serial_port_switch, serial_port_enable, wavetable_port_enable, eeprom_access_enable, wide, c0, c1;
  logic buffered_reset_bit, mcd, eClk, eSda, dOut, dClk, dFs, dacValid, send, left, sIn, c1In, rdStrap, wrStrap;
  logic [2:0] addr;
  logic [11:0] altBase;
  logic [15:0] word;
  ppm_stereo_s dacIn, mixOut;
  logic mixValid, upper, cdEn, irq, sOut, sOe, c1Out, c1Oe, xc0, xa1, xa0, cdN, bresN, rdOut, rdOe, wrOut, wrOe;
  logic align, pcm, dIn, vDn, pRdEn;
  logic [3:0] stickOe;
  logic [7:0] xdOut, xdOe, xdIn;
  int err_total = 0;
  int num_checks = 0;
  wire logic rdIn = rdOe ? rdOut : rdStrap;
  wire logic wrIn = wrOe ? wrOut : wrStrap;
  // ===================================================
  // xd0 pulled up, xd7..6 from the synth model
  always_comb begin
    xdIn = 8'h01;
    xdIn[6] = align;
    xdIn[7] = pcm;
    if (xdOe[0]) xdIn[0] = 1'b0;
  end
  ppm_wavetable_model u_wt (.core_clk(core_clk), .send(send), .left(left), .word(word), .align(align), .pcm(pcm));
  ppm_peripheral_port_pin_mux u_dut (.core_clk(core_clk), .rst(rst), .hostAddr(addr), .hostData(8'hA5),
    .hostReadN(rdN), .hostWriteN(wrN), .synthDecode(sDec), .cdromDecode(cDec), .modemDecode(mDec),
    .altCdromDecode(aDec), .internalFmEnable(fm), .volumePinsEnable(vol), .altCdromBase(altBase),
    .synthIrqPolarity(pol), .serialPortSwitch(serial_port_switch), .serialPortEnable(serial_port_enable), .wavetablePortEnable(wavetable_port_enable),
    .eepromAccessEnable(eeprom_access_enable), .wideAddrEnable(wide), .controlZeroBit(c0), .controlOneBit(c1),
    .bufferedResetBit(buffered_reset_bit), .masterClockDisable(mcd), .eepromClk(eClk), .eepromSdaOut(eSda), .eepromSdaIn(),
    .dspSerialOut(dOut), .dspSerialClk(dClk), .dspFrameSync(dFs), .dspSerialIn(dIn), .dacValid(dacValid),
    .dacIn(dacIn), .mixValid(mixValid), .mixOut(mixOut), .wtDropped(), .upperAddrMode(upper),
    .cdromPortsEnable(cdEn), .synthIrq(irq), .volumeUp(), .volumeDown(vDn), .stickBInputs(), .periphReadData(),
    .periphReadEnable(pRdEn), .synthSelectNOut(sOut), .synthSelectNOe(sOe), .synthSelectNIn(sIn),
    .extControlOneOut(c1Out), .extControlOneOe(c1Oe), .extControlOneIn(c1In), .extControlZero(xc0),
    .extAddrOne(xa1), .extAddrZero(xa0), .cdromSelectN(cdN), .modemSelectN(), .bufferedResetN(bresN),
    .extReadStrobeNOut(rdOut), .extReadStrobeNOe(rdOe), .extReadStrobeNIn(rdIn), .extWriteStrobeNOut(wrOut),
    .extWriteStrobeNOe(wrOe), .extWriteStrobeNIn(wrIn), .extDataBusOut(xdOut), .extDataBusOe(xdOe),
    .extDataBusIn(xdIn), .stickBPinOut(), .stickBPinOe(stickOe), .stickBPinIn(4'hF));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst, sDec, cDec, mDec, aDec, fm, vol, pol, serial_port_switch, serial_port_enable, wavetable_port_enable, eeprom_access_enable, wide, c0, c1} = 15'h4000;
    {buffered_reset_bit, mcd, eClk, eSda, dOut, dClk, dFs, dacValid, send, left} = 10'h010;
    {rdN, wrN, sIn, c1In, rdStrap, wrStrap} = 6'h3C;
    addr = 3'h0;
    altBase = 12'h0;
    word = 16'h0;
    dacIn = '0;
    // ===================================================
    // reset with both straps pulled low
    cyc(20);
    chk("buffered_reset_n", bresN, 1'h0);
    rst <= 1'b0;
    cyc(3);
    rdStrap <= 1'b1;
    wrStrap <= 1'b1;
    cyc(6);
    chk("upper", upper, 1'h0);
    chk("cdEn", cdEn, 1'h1);
    chk("c1Oe", c1Oe, 1'h0);
    c1In <= 1'b0;
    cyc(6);
    chk("irqLow", irq, 1'h1);
    pol <= 1'b1;
    cyc(2);
    chk("irqPol", irq, 1'h0);
    $display("test straps done");
    // ===================================================
    // strobes, selects and address pins
    sDec <= 1'b1;
    rdN <= 1'b0;
    addr <= 3'h6;
    c0 <= 1'b1;
    cyc(1);
    chk("scs", {sOe, sOut, rdOut, wrOut}, 4'h9);
    chk("addr", {xc0, xa1, xa0}, 3'h6);
    wide <= 1'b1;
    addr <= 3'h1;
    cyc(1);
    chk("wide", {xc0, xa1, xa0}, 3'h1);
    fm <= 1'b1;
    eeprom_access_enable <= 1'b1;
    eClk <= 1'b0;
    cyc(1);
    chk("fm", {sOut, rdOut, xa0}, 3'h6);
    {fm, sDec, cDec, rdN, wrN} <= 5'h05;
    cyc(1);
    chk("cd", {cdN, rdOut, wrOut}, 3'h1);
    {cDec, wrN, buffered_reset_bit} <= 3'h3;
    cyc(1);
    chk("buffered_reset_bit", bresN, 1'h0);
    vol <= 1'b1;
    altBase <= 12'h170;
    cyc(2);
    chk("vol", {sOe, c1Oe, vDn}, 3'h1);
    vol <= 1'b0;
    cyc(2);
    chk("alt", {c1Oe, c1Out}, 2'h3);
    $display("test strobes done");
    // ===================================================
    // dsp port on data pins, then on joystick B
    {serial_port_enable, serial_port_switch, dClk, dFs, dOut} <= 5'h1D;
    cyc(2);
    chk("xd", {xdOut[4:1], xdOe[3:1]}, 7'h3D);
    chk("xdIn", {dIn, pRdEn}, 2'h0);
    serial_port_switch <= 1'b0;
    cyc(2);
    chk("stick", {stickOe, dIn}, 5'h1B);
    $display("test serial done");
    // ===================================================
    // wavetable word summed into dac path
    {serial_port_enable, serial_port_switch, wavetable_port_enable} <= 3'h1;
    word <= 16'h1234;
    left <= 1'b1;
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(30);
    chk("mclkOe", {pRdEn, xdOe[7:5]}, 4'h1);
    dacIn <= '{left: 16'h0100, right: 16'h0005};
    dacValid <= 1'b1;
    cyc(1);
    dacValid <= 1'b0;
    for (int i = 0; i < 20 && mixValid !== 1'b1; i++) cyc(1);
    chk("mixValid", mixValid, 1'h1);
    chk("mix", mixOut, 32'h13340005);
    cyc(1);
    dacValid <= 1'b1;
    cyc(1);
    dacValid <= 1'b0;
    chk("mixBare", mixOut, 32'h01000005);
    $display("test wavetable done");
    end_sim();
  end
endmodule

//--- ppm_pkg.sv
// constants and types for the peripheral port pin mux
// Overview of operation
// - synth select pin drives low on a valid external synth decode by default
// - internal synth enabled stops the synth select pin acting as chip select
// - volume pins enable turns the synth select pin into the volume-up input
// - control-1 pin defaults to an output driven by the control-1 bit
// - volume pins enable makes the control-1 pin the volume-down input
// - control-1 pin is synth irq only if no volume, no alt base, write strap low
// - synth irq input is active low unless the polarity bit says otherwise
// - alt cdrom base first non-zero without volume makes control-1 the alt cdrom select
// - serial port switch puts the dsp port on data pins or on joystick B
// - on data pins: clock XD1, data in XD2, data out XD3, frame sync XD4
// - wavetable enable takes data pins XD7 to XD5 for the wavetable port
// - control-0 pin follows control-0 bit, or address bit 2 for wide ports
// - external address pins carry host address bits 1 and 0
// - eeprom access enable turns external address 0 into the eeprom clock
// - data bit 0 is open drain host bit 0, or eeprom data when enabled
// - buffered reset is low while reset is high or the buffered reset bit set
// - external strobes go low on a synth, cdrom or modem chip select with the host strobe low
// - read strobe strap at reset release: high upper address, low cdrom and modem
// - write strobe strap at reset release: high control-1, low synth irq input
// - serial port enable with the switch low turns joystick B pins into dsp serial pins
// - received wavetable samples are summed digitally into the dac path
// - XD5 outputs the master clock in wavetable mode unless clock disable is set
// - volume pins enable overrides every other function of the shared pins
// - reset high holds the block; its release latches both straps
package ppm_pkg;
  // ===================================================
  // sizes
  localparam int PPM_SAMPLE_W = 16;
  localparam int PPM_FIFO_DEPTH = 4;
  localparam int PPM_ALT_BASE_W = 12;
  localparam int PPM_SYNC_W = 16;
  localparam int PPM_WORD_LAST = PPM_SAMPLE_W - 1;
  // ===================================================
  // synchronised input vector positions
  localparam int PPM_IN_SYNTH = 0;
  localparam int PPM_IN_CTL1 = 1;
  localparam int PPM_IN_STRAP_RD = 2;
  localparam int PPM_IN_STRAP_WR = 3;
  localparam int PPM_IN_STICK = 4;
  localparam int PPM_IN_XD = 8;
  // ===================================================
  // joystick B pin positions
  localparam int PPM_STICK_X = 0;
  localparam int PPM_STICK_Y = 1;
  localparam int PPM_STICK_B1 = 2;
  localparam int PPM_STICK_B2 = 3;
  // ===================================================
  // external data pin positions
  localparam int PPM_XD_SER_CLK = 1;
  localparam int PPM_XD_SER_IN = 2;
  localparam int PPM_XD_SER_OUT = 3;
  localparam int PPM_XD_SER_SYNC = 4;
  localparam int PPM_XD_WT_MCLK = 5;
  localparam int PPM_XD_WT_ALIGN = 6;
  localparam int PPM_XD_WT_PCM = 7;
  // ===================================================
  // values after reset and the full bit count
  localparam logic PPM_STRAP_RD_RST = 1'h1;
  localparam logic PPM_STRAP_WR_RST = 1'h1;
  localparam logic [4:0] PPM_BITCNT_RST = 5'h10;
  localparam logic [4:0] PPM_BITCNT_FULL = 5'h10;
  // ===================================================
  // types
  typedef enum logic [1:0] {
    PPM_CTL1_OUT = 2'b00,
    PPM_CTL1_IRQ = 2'b01,
    PPM_CTL1_ALTCD = 2'b10,
    PPM_CTL1_VOLDN = 2'b11
  } ppm_ctl1_mode_e;
  typedef struct packed {
    logic right;
    logic [PPM_SAMPLE_W-1:0] data;
  } ppm_wt_word_s;
  typedef struct packed {
    logic [PPM_SAMPLE_W-1:0] left;
    logic [PPM_SAMPLE_W-1:0] right;
  } ppm_stereo_s;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } ppm_bus_drive_s;
endpackage

//--- ppm_wavetable_model.sv
// behavioural wavetable synth serial source
`timescale 1ns/1ps
module ppm_wavetable_model (
  // clock
  input wire logic core_clk,
  // command
  input wire logic send,
  input wire logic left,
  input wire logic [15:0] word,
  // pins
  output logic align,
  output logic pcm
);
  logic [4:0] cnt;
  logic [15:0] sh;
  initial begin
    align = 1'b0;
    pcm = 1'b0;
    cnt = 5'h0;
    sh = 16'h0;
  end
  // ===================================================
  // word framed by align change, msb first
  always @(posedge core_clk) begin
    if (send) begin
      align <= left;
      pcm <= word[15];
      sh <= word << 1;
      cnt <= 5'hF;
    end else if (cnt != 5'h0) begin
      pcm <= sh[15];
      sh <= sh << 1;
      cnt <= cnt - 5'h1;
    end else begin
      pcm <= ~pcm;
    end
  end
endmodule
